//--- rxsm_consts.svh
`ifndef RXSM_CONSTS_SVH
`define RXSM_CONSTS_SVH

// ---------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define RXSM_IDX_LINK_CTRL 14'h0700
`define RXSM_IDX_SLOT_LOW 14'h0710
`define RXSM_IDX_SLOT_HIGH 14'h0720
`define RXSM_IDX_SYNC_FAULT 14'h0730
`define RXSM_IDX_PATTERN 14'h0741
`define RXSM_IDX_IRQ_MASK 14'h0742
`define RXSM_IDX_IRQ_STATUS 14'h0743

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define RXSM_CTRL_BIT_MODE 10
`define RXSM_CTRL_LINK_EN 7
`define RXSM_PATTERN_W 8

// ---------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------
`define RXSM_RST_16 16'h0000
`define RXSM_RST_PATTERN 8'h00
`define RXSM_LINKS 16
`define RXSM_SLOTS 32
`define RXSM_FRAME_LAST 8'hff

`endif

//--- rxsm_pkg.sv
package rxsm_pkg;
    typedef enum logic [2:0]
    {
        RXSM_BUS_IDLE = 3'b001,
        RXSM_BUS_LOOK = 3'b010,
        RXSM_BUS_ACK = 3'b100
    } rxsm_bus_e;
    typedef logic [15:0] rxsm_word_t;
endpackage

//--- rxsm_map_mem.sv
`timescale 1ns/1ps
`include "rxsm_consts.svh"

module rxsm_map_mem
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [5:0] wr_addr_i,
    input wire logic [1:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [5:0] rd_addr_i,
    output logic [15:0] rd_data_o,
    output logic [511:0] map_o
);
    // word {hi,link}: hi=0 holds slots 15:0, hi=1 holds slots 31:16
    logic [15:0] mem_ff [0:31];
    logic [15:0] rd_data_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 32; i++)
            begin
                mem_ff[i] <= `RXSM_RST_16;
            end
        end
        else if (wr_en_i)
        begin
            if (wr_sel_i[0])
            begin
                mem_ff[wr_addr_i[4:0]][7:0] <= wr_data_i[7:0];
            end
            if (wr_sel_i[1])
            begin
                mem_ff[wr_addr_i[4:0]][15:8] <= wr_data_i[15:8];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_data_ff <= `RXSM_RST_16;
        end
        else
        begin
            rd_data_ff <= mem_ff[rd_addr_i[4:0]];
        end
    end

    assign rd_data_o = rd_data_ff;

    for (genvar n = 0; n < `RXSM_LINKS; n++)
    begin : g_flat
        assign map_o[n*32 +: 32] = {mem_ff[16+n], mem_ff[n]};
    end
endmodule

//--- rxsm_top.sv
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "rxsm_consts.svh"

// Summary of operation
// - each link keeps 32 slot enables; a bit in a disabled slot still shows on rx_cell_bit_o but never raises rx_cell_bit_valid_o.
// - the low map register of a link enables slots 0 to 15, bit n for slot n.
// - the high map register of a link enables slots 16 to 31, bit n for slot n plus 16.
// - one shared register holds a sync fault flag per link, and writing zero to a flag clears it.
// - a per-link control bit picks bit-mode delineation when set and byte mode on frame sync when clear.
module rxsm_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic [15:0] rx_link_clock_i,
    input wire logic [15:0] rx_serial_data_in_i,
    input wire logic [15:0] rx_frame_sync_i,
    output logic [15:0] rx_cell_bit_o,
    output logic [15:0] rx_cell_bit_valid_o,
    output logic [15:0] rx_bit_mode_o,
    output logic [7:0] rx_delin_pattern_o
);
    import rxsm_pkg::*;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic logic in_block(input logic [13:0] idx, input logic [13:0] base);
        in_block = (idx[13:4] == base[13:4]);
    endfunction

    function automatic logic [15:0] merge(input rxsm_word_t old, input rxsm_word_t nw,
                                          input logic [1:0] sel);
        merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    endfunction

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    rxsm_bus_e state_ff;
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [15:0] ctrl_ff [0:15];
    logic [15:0] fault_ff;
    logic [15:0] irq_stat_ff;
    logic [15:0] irq_mask_ff;
    logic [7:0] pattern_ff;
    logic [15:0] mem_rd;
    logic [511:0] map;
    logic [13:0] idx;
    logic wr_now;
    logic is_map;
    logic [15:0] fault_evt;

    assign idx = adr_i;
    assign is_map = in_block(idx, `RXSM_IDX_SLOT_LOW) || in_block(idx, `RXSM_IDX_SLOT_HIGH);
    // writes land on the same edge that raises ack; the master holds the request until then
    assign wr_now = (state_ff == RXSM_BUS_LOOK) && we_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= RXSM_BUS_IDLE;
        end
        else
        begin
            unique case (state_ff)
                RXSM_BUS_IDLE:
                begin
                    if (cyc_i && stb_i)
                    begin
                        state_ff <= RXSM_BUS_LOOK;
                    end
                end
                RXSM_BUS_LOOK:
                begin
                    state_ff <= RXSM_BUS_ACK;
                end
                RXSM_BUS_ACK:
                begin
                    state_ff <= RXSM_BUS_IDLE;
                end
                default:
                begin
                    state_ff <= RXSM_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= (state_ff == RXSM_BUS_LOOK);
            // data only stand with ack, so a stale read never leaks out
            dat_ff <= 32'h0000_0000;
            if (state_ff == RXSM_BUS_LOOK && !we_i)
            begin
                // unmapped registers, bits 31:16 and pattern bits 15:8 read as zero; control words read back all 16 written bits
                dat_ff <= 32'h0000_0000;
                if (is_map)
                begin
                    dat_ff[15:0] <= mem_rd;
                end
                else if (in_block(idx, `RXSM_IDX_LINK_CTRL))
                begin
                    dat_ff[15:0] <= ctrl_ff[idx[3:0]];
                end
                else if (idx == `RXSM_IDX_SYNC_FAULT)
                begin
                    dat_ff[15:0] <= fault_ff;
                end
                else if (idx == `RXSM_IDX_PATTERN)
                begin
                    dat_ff[`RXSM_PATTERN_W-1:0] <= pattern_ff;
                end
                else if (idx == `RXSM_IDX_IRQ_MASK)
                begin
                    dat_ff[15:0] <= irq_mask_ff;
                end
                else if (idx == `RXSM_IDX_IRQ_STATUS)
                begin
                    dat_ff[15:0] <= irq_stat_ff;
                end
            end
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // slot maps live in the memory; the address word {hi,link} follows the index
    rxsm_map_mem u_map
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(wr_now && is_map),
        .wr_addr_i({1'b0, idx[5], idx[3:0]}),
        .wr_sel_i(sel_i[1:0]),
        .wr_data_i(dat_i[15:0]),
        .rd_addr_i({1'b0, idx[5], idx[3:0]}),
        .rd_data_o(mem_rd),
        .map_o(map)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `RXSM_LINKS; i++)
            begin
                ctrl_ff[i] <= `RXSM_RST_16;
            end
        end
        else if (wr_now && in_block(idx, `RXSM_IDX_LINK_CTRL))
        begin
            ctrl_ff[idx[3:0]] <= merge(ctrl_ff[idx[3:0]], dat_i[15:0], sel_i[1:0]);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pattern_ff <= `RXSM_RST_PATTERN;
            irq_mask_ff <= `RXSM_RST_16;
        end
        else if (wr_now)
        begin
            if (idx == `RXSM_IDX_PATTERN && sel_i[0])
            begin
                pattern_ff <= dat_i[7:0];
            end
            if (idx == `RXSM_IDX_IRQ_MASK)
            begin
                irq_mask_ff <= merge(irq_mask_ff, dat_i[15:0], sel_i[1:0]);
            end
        end
    end

    // ---------------------------------------------------------------
    // fault flags and interrupt
    // ---------------------------------------------------------------
    logic [15:0] fault_clr;
    logic [15:0] stat_clr;

    assign fault_clr = (wr_now && idx == `RXSM_IDX_SYNC_FAULT) ?
                       ~merge(16'hffff, dat_i[15:0], sel_i[1:0]) : 16'h0000;
    assign stat_clr = (wr_now && idx == `RXSM_IDX_IRQ_STATUS) ?
                      merge(16'h0000, dat_i[15:0], sel_i[1:0]) : 16'h0000;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_ff <= `RXSM_RST_16;
            irq_stat_ff <= `RXSM_RST_16;
        end
        else
        begin
            fault_ff <= (fault_ff & ~fault_clr) | fault_evt;
            irq_stat_ff <= (irq_stat_ff & ~stat_clr) | fault_evt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(((irq_stat_ff & ~stat_clr) | fault_evt) & irq_mask_ff);
        end
    end

    // ---------------------------------------------------------------
    // link receive path
    // ---------------------------------------------------------------
    logic [15:0] clk_s1_ff, clk_s2_ff, clk_s3_ff;
    logic [15:0] dat_s1_ff, dat_s2_ff;
    logic [15:0] syn_s1_ff, syn_s2_ff;
    logic [7:0] pos_ff [0:15];
    logic [15:0] framed_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clk_s1_ff <= 16'h0000;
            clk_s2_ff <= 16'h0000;
            clk_s3_ff <= 16'h0000;
            dat_s1_ff <= 16'h0000;
            dat_s2_ff <= 16'h0000;
            syn_s1_ff <= 16'h0000;
            syn_s2_ff <= 16'h0000;
        end
        else
        begin
            clk_s1_ff <= rx_link_clock_i;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            dat_s1_ff <= rx_serial_data_in_i;
            dat_s2_ff <= dat_s1_ff;
            syn_s1_ff <= rx_frame_sync_i;
            syn_s2_ff <= syn_s1_ff;
        end
    end

    always_comb
    begin
        fault_evt = 16'h0000;
        for (int n = 0; n < `RXSM_LINKS; n++)
        begin
            // a sync off the frame boundary, or a boundary without sync, is a fault
            if (clk_s2_ff[n] && !clk_s3_ff[n] && ctrl_ff[n][`RXSM_CTRL_LINK_EN]
                && !ctrl_ff[n][`RXSM_CTRL_BIT_MODE] && framed_ff[n]
                && (syn_s2_ff[n] != (pos_ff[n] == 8'h00)))
            begin
                fault_evt[n] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int n = 0; n < `RXSM_LINKS; n++)
            begin
                pos_ff[n] <= 8'h00;
            end
            framed_ff <= 16'h0000;
            rx_cell_bit_o <= 16'h0000;
            rx_cell_bit_valid_o <= 16'h0000;
        end
        else
        begin
            rx_cell_bit_valid_o <= 16'h0000;
            for (int n = 0; n < `RXSM_LINKS; n++)
            begin
                if (!ctrl_ff[n][`RXSM_CTRL_LINK_EN])
                begin
                    framed_ff[n] <= 1'b0;
                    pos_ff[n] <= 8'h00;
                end
                else if (clk_s2_ff[n] && !clk_s3_ff[n])
                begin
                    // byte mode realigns on sync; bit mode free-runs and ignores it
                    if (!ctrl_ff[n][`RXSM_CTRL_BIT_MODE] && syn_s2_ff[n])
                    begin
                        framed_ff[n] <= 1'b1;
                        pos_ff[n] <= 8'h01;
                        rx_cell_bit_valid_o[n] <= map[n*32];
                    end
                    else
                    begin
                        pos_ff[n] <= (pos_ff[n] == `RXSM_FRAME_LAST) ? 8'h00 : pos_ff[n] + 8'h01;
                        rx_cell_bit_valid_o[n] <= map[n*32 + 32'(pos_ff[n][7:3])];
                    end
                    rx_cell_bit_o[n] <= dat_s2_ff[n];
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_bit_mode_o <= 16'h0000;
            rx_delin_pattern_o <= `RXSM_RST_PATTERN;
        end
        else
        begin
            for (int n = 0; n < `RXSM_LINKS; n++)
            begin
                rx_bit_mode_o[n] <= ctrl_ff[n][`RXSM_CTRL_BIT_MODE];
            end
            rx_delin_pattern_o <= pattern_ff;
        end
    end
endmodule

//--- rxsm_assertions.sv
`timescale 1ns/1ps
`include "rxsm_consts.svh"
// ----------------------------------------
// bus and link port checks
// ----------------------------------------
module rxsm_assertions
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:2] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [15:0] rx_link_clock_i,
    input wire logic [15:0] rx_cell_bit_valid_o,
    input wire logic [15:0] rx_bit_mode_o,
    input wire logic [7:0] rx_delin_pattern_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_two_cycles: assert property ((cyc_i && stb_i && !$past(cyc_i && stb_i)) |-> ##2 ack_o)
        else $error("ack not two cycles after request");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ack_o |-> (cyc_i && stb_i))
        else $error("ack without request");
    a_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_upper_read_zero: assert property ((ack_o && !we_i) |-> dat_o[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_valid_gap: assert property ((rx_cell_bit_valid_o & $past(rx_cell_bit_valid_o)) == 16'h0)
        else $error("valid pulse longer than one cycle");
    a_valid_after_clock: assert property (rx_cell_bit_valid_o[0] |-> $past(rx_link_clock_i[0], 3))
        else $error("valid without link clock edge");
    a_mode_follows: assert property ((ack_o && we_i && adr_i == `RXSM_IDX_LINK_CTRL && sel_i[1])
        |=> rx_bit_mode_o[0] == $past(dat_i[`RXSM_CTRL_BIT_MODE]))
        else $error("bit mode output not updated");
    a_pattern_follows: assert property ((ack_o && we_i && adr_i == `RXSM_IDX_PATTERN && sel_i[0])
        |=> rx_delin_pattern_o == $past(dat_i[7:0]))
        else $error("pattern output not updated");
endmodule

//--- rxsm_framer.sv
`timescale 1ns/1ps
// ----------------------------------------
// framer model: one 256 bit frame per run pulse
// ----------------------------------------
module rxsm_framer
(
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic bad_i,
    output logic [15:0] lclk_o,
    output logic [15:0] data_o,
    output logic [15:0] sync_o
);
    logic act_ff = 1'b0;
    logic [2:0] ph_ff = 3'h0;
    logic [7:0] bit_ff = 8'h00;
    logic last_ff = 1'b0;
    always_ff @(posedge clk_i)
    begin
        if (!act_ff)
        begin
            act_ff <= run_i;
            ph_ff <= 3'h0;
            bit_ff <= 8'h00;
        end
        else
        begin
            ph_ff <= ph_ff + 3'h1;
            if (ph_ff == 3'h7)
                bit_ff <= bit_ff + 8'h01;
            if (ph_ff == 3'h7 && bit_ff == 8'hff)
                act_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk_i)
        if (act_ff)
            last_ff <= bit_ff[0] ^ bit_ff[3];
    // clock stands still between frames, data then shows the inverse of its last bit
    assign lclk_o = {16{act_ff & ph_ff[2]}};
    assign data_o = act_ff ? {16{bit_ff[0] ^ bit_ff[3]}} : {16{~last_ff}};
    // a faulty frame marks bit 5 so the receiver must flag it
    assign sync_o = {16{act_ff && bit_ff == (bad_i ? 8'h05 : 8'h00)}};
endmodule

//--- tdm_rx_slot_map_sync_tb_top.sv
`timescale 1ns/1ps
`include "rxsm_consts.svh"
module tdm_rx_slot_map_sync_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [13:0] adr_i = 14'h0000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic irq_o;
    logic [15:0] lclk, sdat, fsync, cbit, cval, bmode;
    logic [7:0] pat;
    logic run = 1'b0;
    logic bad = 1'b0;
    logic [15:0] q;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int cnt [16];
    always #12.5 clk_i = ~clk_i;
    rxsm_top rxsm_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .rx_link_clock_i(lclk), .rx_serial_data_in_i(sdat),
        .rx_frame_sync_i(fsync), .rx_cell_bit_o(cbit), .rx_cell_bit_valid_o(cval),
        .rx_bit_mode_o(bmode), .rx_delin_pattern_o(pat));
    rxsm_framer rxsm_framer_inst (.clk_i(clk_i), .run_i(run), .bad_i(bad), .lclk_o(lclk),
        .data_o(sdat), .sync_o(fsync));
    task tally_and_finish;
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        for (int i = 0; i < 16; i++)
            cnt[i] <= run ? 0 : cnt[i] + (cval[i] === 1'b1);
        if (cycles == 20000)
        begin
            failures = failures + 1;
            tally_and_finish();
        end
    end
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic cycle; only the global timeout ends the wait for ack
    task bus(input logic w, input logic [13:0] a, input logic [15:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {16'h0000, d};
        do
        begin
            @(posedge clk_i);
        end
        while (ack_o !== 1'b1);
        q = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task wr(input logic [13:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [13:0] a, input logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        chk($sformatf("reg %h", a), exp, q);
    endtask
    task frame(input logic b);
        bad <= b;
        run <= 1'b1;
        @(posedge clk_i);
        run <= 1'b0;
        repeat (2100) @(posedge clk_i);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`RXSM_IDX_SLOT_LOW, 16'h0000);
        rd(`RXSM_IDX_SLOT_HIGH, 16'h0000);
        rd(`RXSM_IDX_SYNC_FAULT, 16'h0000);
        rd(`RXSM_IDX_PATTERN, 16'h0000);
        wr(`RXSM_IDX_SLOT_LOW, 16'h8001);
        wr(`RXSM_IDX_SLOT_HIGH, 16'h8000);
        wr(`RXSM_IDX_SLOT_LOW + 14'h2, 16'h00ff);
        rd(`RXSM_IDX_SLOT_LOW, 16'h8001);
        rd(`RXSM_IDX_SLOT_HIGH, 16'h8000);
        wr(`RXSM_IDX_PATTERN, 16'hff36);
        rd(`RXSM_IDX_PATTERN, 16'h0036);
        wr(14'h0600, 16'hffff);
        rd(14'h0600, 16'h0000);
        // links 0 to 2 byte mode, link 3 bit mode, others stay off
        for (int i = 0; i < 3; i++)
            wr(`RXSM_IDX_LINK_CTRL + 14'(i), 16'h0080);
        wr(`RXSM_IDX_LINK_CTRL + 14'h3, 16'h0480);
        // the mode output is a register behind the control word, one edge later
        @(posedge clk_i);
        chk("bit_mode", 16'h0008, bmode);
        chk("pattern_out", 16'h0036, {8'h00, pat});
        frame(1'b0);
        chk("valid_link0", 16'h0018, 16'(cnt[0]));
        chk("valid_link1", 16'h0000, 16'(cnt[1]));
        chk("valid_link2", 16'h0040, 16'(cnt[2]));
        chk("valid_link5", 16'h0000, 16'(cnt[5]));
        rd(`RXSM_IDX_SYNC_FAULT, 16'h0000);
        frame(1'b1);
        rd(`RXSM_IDX_SYNC_FAULT, 16'h0007);
        rd(`RXSM_IDX_IRQ_STATUS, 16'h0007);
        chk("irq_masked", 16'h0000, {15'h0, irq_o});
        wr(`RXSM_IDX_IRQ_MASK, 16'h0001);
        rd(`RXSM_IDX_SYNC_FAULT, 16'h0007);
        chk("irq_on", 16'h0001, {15'h0, irq_o});
        wr(`RXSM_IDX_SYNC_FAULT, 16'hfffe);
        rd(`RXSM_IDX_SYNC_FAULT, 16'h0006);
        wr(`RXSM_IDX_IRQ_STATUS, 16'h0001);
        rd(`RXSM_IDX_IRQ_STATUS, 16'h0006);
        chk("irq_off", 16'h0000, {15'h0, irq_o});
        tally_and_finish();
    end
endmodule
bind rxsm_top rxsm_assertions rxsm_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rx_link_clock_i(rx_link_clock_i),
    .rx_cell_bit_valid_o(rx_cell_bit_valid_o), .rx_bit_mode_o(rx_bit_mode_o),
    .rx_delin_pattern_o(rx_delin_pattern_o));
